// file: common/rrx_pkg.sv
/*
  Constants shared by the return and rotate execution unit: widths, field
  positions, reset values, cycle counts and the operation encoding.
  Assumes a core that decodes instructions upstream and hands over one
  operation code per instruction start.
*/
package rrx_pkg;

  // Data path widths
  localparam int DATA_W = 8;
  localparam int PC_W   = 15;
  localparam int ADDR_W = 7;

  // Field positions
  localparam int GIE_BIT   = 7;
  localparam int MSB_BIT   = 7;
  localparam int LSB_BIT   = 0;

  // Destination select encodings
  localparam logic DEST_WREG = 1'h0;
  localparam logic DEST_FILE = 1'h1;

  // Cycle counts
  localparam int RET_CYCLES = 2;
  localparam int ROT_CYCLES = 1;

  // Reset values
  localparam logic [7:0]  W_RST    = 8'h00;
  localparam logic [14:0] PC_RST   = 15'h0000;
  localparam logic [7:0]  ICR_RST  = 8'h00;
  localparam logic        C_RST    = 1'h0;

  // Operation codes presented with op_start
  typedef enum logic [2:0]
  {
    RRX_OP_NONE   = 3'h0,
    RRX_OP_RETFI  = 3'h1,
    RRX_OP_RETSUB = 3'h2,
    RRX_OP_RETLIT = 3'h3,
    RRX_OP_ROTL   = 3'h4,
    RRX_OP_ROTR   = 3'h5
  } rrx_op_t;

  // Sequencer states, one-hot
  typedef enum logic [2:0]
  {
    RRX_IDLE = 3'h1,
    RRX_RET2 = 3'h2,
    RRX_DONE = 3'h4
  } rrx_state_t;

endpackage : rrx_pkg

// file: design/rrx_exec.sv
/*
  Execution unit for the return instructions and the carry rotates.
  Assumes the core pops its return stack when pop_req pulses and presents
  the entry to be popped on top_of_stack with op_start, that file register
  data is presented on file_rdata with op_start, and that op_start is only
  raised while busy is low.
*/
`timescale 1ns/1ps

module rrx_exec #(
  parameter int DATA_W = rrx_pkg::DATA_W,
  parameter int PC_W   = rrx_pkg::PC_W,
  parameter int ADDR_W = rrx_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  // Instruction issue
  input  wire logic              op_start,
  input  wire logic [2:0]        op_code,
  input  wire logic [DATA_W-1:0] op_literal,
  input  wire logic [ADDR_W-1:0] op_faddr,
  input  wire logic              op_dest,
  // Return stack
  input  wire logic [PC_W-1:0]   top_of_stack,
  output logic                   pop_req,
  // File register port
  input  wire logic [DATA_W-1:0] file_rdata,
  output logic                   file_we,
  output logic [ADDR_W-1:0]      file_waddr,
  output logic [DATA_W-1:0]      file_wdata,
  // Architectural state
  output logic [PC_W-1:0]        pc,
  output logic [DATA_W-1:0]      wreg,
  output logic                   carry,
  output logic [DATA_W-1:0]      interrupt_control_reg,
  // Sequencing
  output logic                   busy,
  output logic                   done
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  rrx_pkg::rrx_state_t state_q, state_d;
  logic [PC_W-1:0]   pc_q, pc_d;
  logic [DATA_W-1:0] w_q, w_d;
  logic              c_q, c_d;
  logic [DATA_W-1:0] icr_q, icr_d;
  logic              pop_q, pop_d;
  logic              we_q, we_d;
  logic [ADDR_W-1:0] wa_q, wa_d;
  logic [DATA_W-1:0] wd_q, wd_d;
  logic              done_q, done_d;
  logic [2:0]        pend_q, pend_d;
  logic              busy_q;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  //
  // A start is decoded in every state, but only the idle branch of the
  // sequencer acts on it: a start while busy is dropped, and codes
  // outside the table fall through with no effect at all.

  wire is_retfi  = op_start && (op_code == 3'(rrx_pkg::RRX_OP_RETFI));
  wire is_retsub = op_start && (op_code == 3'(rrx_pkg::RRX_OP_RETSUB));
  wire is_retlit = op_start && (op_code == 3'(rrx_pkg::RRX_OP_RETLIT));
  wire is_rotl   = op_start && (op_code == 3'(rrx_pkg::RRX_OP_ROTL));
  wire is_rotr   = op_start && (op_code == 3'(rrx_pkg::RRX_OP_ROTR));
  wire is_ret    = is_retfi || is_retsub || is_retlit;
  wire is_rot    = is_rotl || is_rotr;
  // Busy gets a flop of its own so the port never shows a decode of the
  // state bits; it is high exactly while the sequencer sits in the
  // second cycle of a return.
  wire busy_d    = (state_d == rrx_pkg::RRX_RET2);

  // Rotate results through carry
  // Carry in is the flag as it stands; the new carry is written in the
  // same cycle, so back to back rotates chain through it.
  wire [DATA_W-1:0] rotl_res =
    {file_rdata[DATA_W-2:0], c_q};
  wire [DATA_W-1:0] rotr_res =
    {c_q, file_rdata[DATA_W-1:1]};
  wire rotl_c = file_rdata[rrx_pkg::MSB_BIT];
  wire rotr_c = file_rdata[rrx_pkg::LSB_BIT];
  wire [DATA_W-1:0] rot_res = is_rotl ? rotl_res : rotr_res;
  wire rot_c = is_rotl ? rotl_c : rotr_c;
  wire rot_to_w    = is_rot && (op_dest == rrx_pkg::DEST_WREG);
  wire rot_to_file = is_rot && (op_dest == rrx_pkg::DEST_FILE);

  ////////////////////////////////////////////////////////////////////////////
  // Next state. Returns pop and load PC in their first cycle and commit W and the
  // interrupt enable in the second, so the core sees the new PC while the
  // pop is in flight; the trade is one register of pending opcode.

  always_comb
  begin
    state_d = state_q;
    pc_d    = pc_q;
    w_d     = w_q;
    c_d     = c_q;
    icr_d   = icr_q;
    pop_d   = 1'b0;
    we_d    = 1'b0;
    wa_d    = wa_q;
    wd_d    = wd_q;
    done_d  = 1'b0;
    pend_d  = pend_q;
    case (state_q)
      rrx_pkg::RRX_IDLE:
      begin
        if (is_ret)
        begin
          pop_d   = 1'b1;
          pc_d    = top_of_stack;
          pend_d  = op_code;
          wd_d    = op_literal;         // Literal held for the second cycle
          state_d = rrx_pkg::RRX_RET2;
        end
        else if (is_rot)
        begin
          c_d    = rot_c;
          done_d = 1'b1;
          if (rot_to_w)
            w_d = rot_res;
          if (rot_to_file)
          begin
            we_d = 1'b1;
            wa_d = op_faddr;
            wd_d = rot_res;
          end
        end
      end
      rrx_pkg::RRX_RET2:
      begin
        // Second cycle of a return; status and carry stay as they were
        // The literal has waited in the write data flop since the first
        // cycle, so the core need not hold op_literal.
        done_d  = 1'b1;
        state_d = rrx_pkg::RRX_IDLE;
        if (pend_q == 3'(rrx_pkg::RRX_OP_RETLIT))
          w_d = wd_q;
        if (pend_q == 3'(rrx_pkg::RRX_OP_RETFI))
          icr_d[rrx_pkg::GIE_BIT] = 1'b1;
      end
      default:
      begin
        state_d = rrx_pkg::RRX_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers. W is only written by a rotate to W or a literal
  // return, never by the other returns.

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      state_q <= rrx_pkg::RRX_IDLE;
      pc_q    <= rrx_pkg::PC_RST;
      w_q     <= rrx_pkg::W_RST;
      c_q     <= rrx_pkg::C_RST;
      icr_q   <= rrx_pkg::ICR_RST;
      pop_q   <= 1'b0;
      we_q    <= 1'b0;
      wa_q    <= '0;
      wd_q    <= '0;
      done_q  <= 1'b0;
      pend_q  <= 3'(rrx_pkg::RRX_OP_NONE);
      busy_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      pc_q    <= pc_d;
      w_q     <= w_d;
      c_q     <= c_d;
      icr_q   <= icr_d;
      pop_q   <= pop_d;
      we_q    <= we_d;
      wa_q    <= wa_d;
      wd_q    <= wd_d;
      done_q  <= done_d;
      pend_q  <= pend_d;
      busy_q  <= busy_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops; busy is the registered
  // state, so a start in the cycle busy falls is accepted.
  // Limitation: the unit keeps no copy of the stack, so pc takes
  // whatever the core shows on top_of_stack at issue, even when the
  // stack is empty; underflow has to be caught by the core.
  // file_wdata also shows the held literal after a return.

  assign pc                    = pc_q;
  assign wreg                  = w_q;
  assign carry                 = c_q;
  assign interrupt_control_reg = icr_q;
  assign pop_req               = pop_q;
  assign file_we               = we_q;
  assign file_waddr            = wa_q;
  assign file_wdata            = wd_q;
  assign done                  = done_q;
  assign busy                  = busy_q;

endmodule : rrx_exec

// file: sim/rrx_exec_monitor.sv
/*
  Port checker for the return and rotate unit.
  Assumes it is bound to rrx_exec and sees only that module's ports.
*/
`timescale 1ns/1ps
module rrx_exec_monitor (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        nrst,
  // Issue
  input wire logic        op_start,
  input wire logic [2:0]  op_code,
  input wire logic [7:0]  op_literal,
  input wire logic [6:0]  op_faddr,
  input wire logic        op_dest,
  input wire logic [14:0] top_of_stack,
  input wire logic [7:0]  file_rdata,
  // Results
  input wire logic        pop_req,
  input wire logic        file_we,
  input wire logic [6:0]  file_waddr,
  input wire logic [7:0]  wreg,
  input wire logic [14:0] pc,
  input wire logic        carry,
  input wire logic [7:0]  interrupt_control_reg,
  input wire logic        busy,
  input wire logic        done
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Accepted issues; a start while busy is dropped, so it is left out
  wire take = op_start && !busy;
  wire ret  = take && op_code inside {3'h1, 3'h2, 3'h3};
  wire rot  = take && op_code inside {3'h4, 3'h5};
  a_ret_pop_pc: assert property (
    ret |=> pop_req && pc == $past(top_of_stack))
    else $error("return did not pop into pc");
  a_ret_two_cyc: assert property (
    ret |=> busy && !done ##1 done && !busy)
    else $error("return did not take two cycles");
  a_gie_set: assert property (
    take && op_code == 3'h1 |=> ##1 interrupt_control_reg[7])
    else $error("interrupt enable not set");
  a_lit_load: assert property (
    take && op_code == 3'h3 |=> ##1 wreg == $past(op_literal, 2))
    else $error("literal not loaded");
  a_ret_keep_w: assert property (
    take && op_code inside {3'h1, 3'h2} |=> ##1 wreg == $past(wreg, 2))
    else $error("return changed w");
  a_ret_keep_c: assert property (
    ret |=> ##1 carry == $past(carry, 2))
    else $error("return changed carry");
  a_rotl_carry: assert property (
    take && op_code == 3'h4 |=> carry == $past(file_rdata[7]))
    else $error("left rotate carry wrong");
  a_rotr_carry: assert property (
    take && op_code == 3'h5 |=> carry == $past(file_rdata[0]))
    else $error("right rotate carry wrong");
  // The write address only moves with a write; otherwise it holds
  a_rot_dest: assert property (
    rot |=> file_we == $past(op_dest) &&
      (file_we ? file_waddr == $past(op_faddr) : $stable(file_waddr)))
    else $error("rotate destination wrong");
  a_rot_one: assert property (
    rot |=> done && !busy && !pop_req)
    else $error("rotate not single cycle");
endmodule : rrx_exec_monitor

// file: sim/rrx_exec_test.sv
/*
  Self-checking bench for the return and rotate unit.
  Assumes an 8 ns clock and that nothing else drives the unit.
*/
`timescale 1ns/1ps
module rrx_exec_test;
  // Stimulus and observed ports
  logic        ref_clk, nrst, op_start, op_dest, pop_req, file_we;
  logic        carry, busy, done;
  logic [2:0]  op_code;
  logic [6:0]  op_faddr, file_waddr;
  logic [7:0]  op_literal, file_rdata, file_wdata, wreg, interrupt_control_reg;
  logic [14:0] top_of_stack, pc;
  int          err_total, n_compared;
  // Rows: code, dest, source, result, carry out (carry chains row to row)
  logic [20:0] rows [6] = '{{3'h4, 1'h0, 8'hE6, 8'hCC, 1'h1},
    {3'h5, 1'h1, 8'h01, 8'h80, 1'h1}, {3'h4, 1'h1, 8'h80, 8'h01, 1'h1},
    {3'h5, 1'h0, 8'hFE, 8'hFF, 1'h0}, {3'h4, 1'h0, 8'h7F, 8'hFE, 1'h0},
    {3'h5, 1'h1, 8'h00, 8'h00, 1'h0}};
  logic [7:0]  w_m;
  rrx_exec rrx_exec_inst (.ref_clk(ref_clk), .nrst(nrst), .op_start(op_start),
    .op_code(op_code), .op_literal(op_literal), .op_faddr(op_faddr),
    .op_dest(op_dest), .top_of_stack(top_of_stack), .pop_req(pop_req),
    .file_rdata(file_rdata), .file_we(file_we), .file_waddr(file_waddr),
    .file_wdata(file_wdata), .pc(pc), .wreg(wreg), .carry(carry),
    .interrupt_control_reg(interrupt_control_reg), .busy(busy), .done(done));
  //////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // Raise one issue and return after the edge that takes it
  task go(input logic [2:0] c, input logic d, input logic [7:0] v,
          input logic [14:0] t);
    @(posedge ref_clk);
    op_start     <= 1'h1;
    op_code      <= c;
    op_dest      <= d;
    file_rdata   <= v;
    op_literal   <= v;
    top_of_stack <= t;
    @(posedge ref_clk);
  endtask : go
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Watchdog sized well above the expected run
  initial
  begin
    #20000;
    err_total++;
    summarize();
  end
  initial
  begin
    {nrst, op_start, op_dest, op_code, op_literal, file_rdata} = '0;
    top_of_stack = 15'h0000;
    op_faddr = 7'h7F;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'h1;
    #1 chk(pc, 15'h0000);
    chk({wreg, carry, interrupt_control_reg, busy, done}, 19'h0);
    w_m = 8'h00;
    foreach (rows[i])
    begin
      go(rows[i][20:18], rows[i][17], rows[i][16:9], 15'h0000);
      op_start <= 1'h0;
      #1 chk(carry, rows[i][0]);
      if (!rows[i][17])
        w_m = rows[i][8:1];
      chk(wreg, w_m);
      chk(file_we, rows[i][17]);
      if (rows[i][17])
        chk({file_waddr, file_wdata}, {7'h7F, rows[i][8:1]});
      chk({done, busy, pop_req, interrupt_control_reg}, 11'h400);
    end
    // Unknown code is ignored
    go(3'h7, 1'h0, 8'h55, 15'h1234);
    op_start <= 1'h0;
    #1 chk({done, pop_req, pc}, 17'h0);
    // Returns, each with a start during busy that must be dropped
    for (int j = 1; j < 5; j++)
    begin
      go(j == 4 ? 3'h3 : j[2:0], 1'h0, j == 3 ? 8'hFF : 8'h00,
         j == 1 ? 15'h7FFF : 15'h4000 + 15'(j));
      op_code <= 3'h4;
      #1 chk({pop_req, busy, done}, 3'h6);
      chk(pc, j == 1 ? 15'h7FFF : 15'h4000 + 15'(j));
      @(posedge ref_clk);
      op_start <= 1'h0;
      if (j >= 3)
        w_m = j == 3 ? 8'hFF : 8'h00;
      #1 chk({done, busy, pop_req, file_we}, 4'h8);
      chk(wreg, w_m);
      chk(interrupt_control_reg, 8'h80);
      chk(carry, 1'h0);
    end
    // Reset in the second cycle of a literal return clears all state
    go(3'h3, 1'h0, 8'hA5, 15'h1111);
    op_start <= 1'h0;
    nrst     <= 1'h0;
    @(posedge ref_clk);
    // Release with a left rotate already waiting at the first edge
    nrst       <= 1'h1;
    op_start   <= 1'h1;
    op_code    <= 3'h4;
    file_rdata <= 8'h81;
    #1 chk(pc, 15'h0000);
    chk({wreg, carry, interrupt_control_reg, busy, done, pop_req}, 20'h0);
    @(posedge ref_clk);
    op_start <= 1'h0;
    #1 chk({wreg, carry, done}, 10'h00B);
    @(posedge ref_clk);
    #1 chk({done, busy, pop_req, pc}, 18'h0);
    summarize();
  end
endmodule : rrx_exec_test
bind rrx_exec rrx_exec_monitor rrx_exec_monitor_inst (.*);
